/* core/bisync_core.sv */
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - two block checks one character apart; include bit clear drops the latest byte
// - transparent off: strip SYNC, recognise control characters
// - transparent on: SYNC, DLE, control special only after a DLE
// - transparent mode always accumulates CRC16
// - reverse bit sends and takes characters MSB first
// - gate bit holds receiver off while RTS is active
// - receive parity: 00 odd, 01 zero, 10 even, 11 one
// - parity settings only act with longitudinal sum; changeable live
// - transmit parity: 00 odd, 01 zero, 10 even, 11 one
// - odd parity makes total ones odd; receive parity error checked only with longitudinal sum outside transparent
// - close buffer, flag, advance on control, error, full, hunt, close command
// - owned descriptor belongs to controller; cleared on close or error
// - wrap bit returns to table base; table length set by wrap
// - notify bit sets receive buffer event on close
// - continuous keeps owned set after close, except on error
// - descriptor records dpll fault, overrun, carrier lost
// - length counts each character written, preset zero by software
// - software leaves ready descriptors alone; controller clears ready when done
// - transmit notify sets done or error event
// - last-in-block returns to normal idle after char and optional check
// - check select 11 is longitudinal sum; only then parity outside transparent
// - with parity, characters are seven data bits plus parity
module bisync_core
  import bisync_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        line_clk_in,
  input  wire logic        rxd_in,
  input  wire logic        carrier_detect_n_in,
  input  wire logic        clear_to_send_n_in,
  input  wire logic        dpll_fault_in,
  output logic             txd_out,
  output logic             rts_out
);

  logic [4:0]      pin_s1;
  logic [4:0]      pin_s2;
  logic            line_d;
  logic            wr_pend;
  logic [7:0]      wr_addr;
  mode_t           mode;
  logic [IDX_W-1:0] rx_base;
  logic [IDX_W-1:0] tx_base;
  logic [IDX_W-1:0] rx_cur;
  logic [IDX_W-1:0] tx_cur;
  logic [15:0]     rx_acc;
  logic [15:0]     rx_acc_prev;
  logic [15:0]     tx_acc;
  logic [15:0]     events;
  rx_desc_t        rx_desc [DESC_N];
  tx_desc_t        tx_desc [DESC_N];
  rx_state_t       rx_state;
  tx_state_t       tx_state;
  logic [7:0]      rx_shift;
  logic [2:0]      rx_cnt;
  logic            rx_byte_valid;
  logic [7:0]      rx_byte;
  logic [7:0]      tx_shift;
  logic [2:0]      tx_cnt;
  rx_desc_t        next_rx_word;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] check_step(input logic crc, input logic [15:0] c,
                                             input logic [7:0] d);
    return crc ? crc_byte(c, d) : {c[15:8], c[7:0] ^ d};
  endfunction

  // parity bit sits in bit 7 above seven data bits
  function automatic logic parity_ok(input logic [7:0] d, input logic [1:0] sel);
    logic ones;
    ones = ^d;
    unique case (sel)
      PAR_ODD:  parity_ok = ones;
      PAR_LOW:  parity_ok = ~d[7];
      PAR_EVEN: parity_ok = ~ones;
      PAR_HIGH: parity_ok = d[7];
    endcase
  endfunction

  function automatic logic parity_gen(input logic [6:0] d, input logic [1:0] sel);
    unique case (sel)
      PAR_ODD:  parity_gen = ~^d;
      PAR_LOW:  parity_gen = 1'b0;
      PAR_EVEN: parity_gen = ^d;
      PAR_HIGH: parity_gen = 1'b1;
    endcase
  endfunction

  function automatic logic desc_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:4] == base[7:4];
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [IDX_W-1:0] k;
    k = a[IDX_W+1:2];
    if (desc_hit(a, RX_DESC_OFS)) read_word = rx_desc[k];
    else if (desc_hit(a, TX_DESC_OFS)) read_word = tx_desc[k];
    else begin
      unique case (a)
        MODE_OFS:    read_word = {16'h0000, mode};
        RX_BASE_OFS: read_word = {30'h00000000, rx_base};
        TX_BASE_OFS: read_word = {30'h00000000, tx_base};
        RX_ACC_OFS:  read_word = {16'h0000, mode.receive_check_include ? rx_acc : rx_acc_prev};
        EVENT_OFS:   read_word = {16'h0000, events};
        STATE_OFS:   read_word = {24'h000000, rx_state, tx_state, rx_cur, tx_cur};
        default:     read_word = 32'h00000000;
      endcase
    end
  endfunction

  // link pins: two flops before use, edges found from second and third stage
  wire line_lvl   = pin_s2[4];
  wire rxd_lvl    = pin_s2[3];
  wire cd_off     = pin_s2[2];
  wire cts_off    = pin_s2[1];
  wire dpll_lvl   = pin_s2[0];
  wire line_rise  = line_lvl & ~line_d;
  wire line_fall  = ~line_lvl & line_d;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      line_d <= 1'b0;
    end else begin
      pin_s1 <= {line_clk_in, rxd_in, carrier_detect_n_in, clear_to_send_n_in, dpll_fault_in};
      pin_s2 <= pin_s1;
      line_d <= line_lvl;
    end
  end

  // bus slave: zero wait, read data captured at the address phase
  wire addr_ok     = hsel_in & htrans_in[1] & hready_in;
  wire sw_mode     = wr_pend & (wr_addr == MODE_OFS);
  wire sw_rx_base  = wr_pend & (wr_addr == RX_BASE_OFS);
  wire sw_tx_base  = wr_pend & (wr_addr == TX_BASE_OFS);
  wire sw_acc      = wr_pend & (wr_addr == RX_ACC_OFS);
  wire sw_cmd      = wr_pend & (wr_addr == CMD_OFS);
  wire sw_event    = wr_pend & (wr_addr == EVENT_OFS);
  wire sw_rx_desc  = wr_pend & desc_hit(wr_addr, RX_DESC_OFS);
  wire sw_tx_desc  = wr_pend & desc_hit(wr_addr, TX_DESC_OFS);
  wire [IDX_W-1:0] wr_idx = wr_addr[IDX_W+1:2];
  wire cmd_hunt    = sw_cmd & hwdata_in[CMD_HUNT_BIT];
  wire cmd_close   = sw_cmd & hwdata_in[CMD_CLOSE_BIT];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_pend       <= 1'b0;
      wr_addr       <= 8'h00;
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend       <= addr_ok & hwrite_in;
      wr_addr       <= haddr_in[7:0];
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (addr_ok && !hwrite_in) hrdata_out <= read_word(haddr_in[7:0]);
    end
  end

  // receiver
  wire rx_active = ~(mode.receive_gate_during_transmit & rts_out);
  wire [7:0] next_shift = mode.bit_order_reverse ? {rx_shift[6:0], rxd_lvl}
                                                 : {rxd_lvl, rx_shift[7:1]};
  wire transparent = mode.receive_transparent;
  wire is_sync     = rx_byte == SYNC_CHAR;
  wire is_dle      = rx_byte == DLE_CHAR;
  wire is_ctrl     = rx_byte == CTRL_CHAR;
  wire in_msg      = rx_state != RX_HUNT;
  wire cd_lost     = cd_off & in_msg;
  wire dpll_err    = dpll_lvl & in_msg;
  wire rx_owned    = rx_desc[rx_cur].owned;
  wire sw_hit_cur  = sw_rx_desc & (wr_idx == rx_cur);
  // transparent: only an escaped SYNC is stripped, a bare DLE starts an escape
  wire rx_keep = rx_byte_valid & ~cd_lost &
                 ((rx_state == RX_ESC) ? ~is_sync :
                  (transparent ? ~is_dle : ~is_sync));
  wire ctrl_hit = rx_byte_valid & is_ctrl &
                  ((rx_state == RX_ESC) | (rx_state == RX_DATA & ~transparent));
  wire store_en    = rx_keep & rx_owned & ~sw_hit_cur;
  // a descriptor write colliding with a store loses the byte
  wire overrun_ev  = rx_keep & rx_owned & sw_hit_cur;
  wire busy_ev     = rx_keep & ~rx_owned;
  wire par_on      = (mode.check_sel == CHECK_LRC) & ~transparent;
  wire par_bad     = store_en & par_on &
                     ~parity_ok(rx_byte, mode.receive_parity_select);
  wire [15:0] len_inc = rx_desc[rx_cur].length + 16'h0001;
  wire full_hit    = store_en & (len_inc == RX_BUF_LEN);
  wire rx_err      = cd_lost | dpll_err | overrun_ev | par_bad;
  wire rx_close    = rx_owned & (rx_err | (ctrl_hit & rx_keep) | full_hit |
                                 cmd_close | cmd_hunt);
  wire rx_goto_hunt = rx_err | cmd_hunt | busy_ev | (ctrl_hit & rx_keep);
  wire use_crc     = transparent | (mode.check_sel != CHECK_LRC);
  wire [15:0] acc_base = mode.receive_check_include ? rx_acc : rx_acc_prev;
  rx_state_t rx_state_after;
  assign rx_state_after = (rx_state == RX_ESC) ? RX_DATA :
                          ((transparent && is_dle) ? RX_ESC : rx_state);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_state      <= RX_HUNT;
      rx_shift      <= 8'h00;
      rx_cnt        <= 3'h0;
      rx_byte_valid <= 1'b0;
      rx_byte       <= 8'h00;
    end else begin
      rx_byte_valid <= 1'b0;
      if (rx_goto_hunt) rx_state <= RX_HUNT;
      else if (rx_byte_valid) rx_state <= rx_state_after;
      if (line_rise && rx_active) begin
        rx_shift <= next_shift;
        rx_cnt   <= rx_cnt + 3'h1;
        if (rx_state == RX_HUNT && next_shift == SYNC_CHAR) begin
          rx_state <= RX_DATA;
          rx_cnt   <= 3'h0;
        end else if (in_msg && rx_cnt == LAST_BIT) begin
          rx_byte_valid <= 1'b1;
          rx_byte       <= next_shift;
        end
      end
    end
  end

  // the lagging copy lets software strip the last byte after seeing it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_acc      <= 16'h0000;
      rx_acc_prev <= 16'h0000;
    end else if (store_en) begin
      rx_acc_prev <= acc_base;
      rx_acc      <= check_step(use_crc, acc_base, rx_byte);
    end else if (sw_acc) begin
      rx_acc      <= hwdata_in[15:0];
      rx_acc_prev <= hwdata_in[15:0];
    end
  end

  always_comb begin
    next_rx_word = rx_desc[rx_cur];
    if (store_en) begin
      next_rx_word.length    = len_inc;
      next_rx_word.last_char = rx_byte;
    end
    if (rx_close) begin
      next_rx_word.dpll_fault_flag   = rx_desc[rx_cur].dpll_fault_flag | dpll_err;
      next_rx_word.rx_overrun_flag   = rx_desc[rx_cur].rx_overrun_flag | overrun_ev;
      next_rx_word.carrier_lost_flag = rx_desc[rx_cur].carrier_lost_flag | cd_lost;
      next_rx_word.parity_error      = rx_desc[rx_cur].parity_error | par_bad;
      next_rx_word.owned = rx_desc[rx_cur].descriptor_continuous & ~rx_err;
    end
  end

  // transmitter
  wire tx_rev      = mode.bit_order_reverse;
  tx_desc_t tx_word;
  assign tx_word   = tx_desc[tx_cur];
  wire tx_par_on   = mode.check_sel == CHECK_LRC;
  wire [7:0] tx_char = tx_par_on ? {parity_gen(tx_word.data[6:0], mode.transmit_parity_select),
                                    tx_word.data[6:0]} : tx_word.data;
  wire tx_load     = (tx_state == TX_IDLE) & line_fall & tx_word.ready;
  wire tx_cts_lost = (tx_state == TX_CHAR) & cts_off;
  wire tx_char_end = (tx_state != TX_IDLE) & line_fall & (tx_cnt == LAST_BIT) & ~tx_cts_lost;
  wire tx_to_check = tx_char_end & (tx_state == TX_CHAR) & tx_word.last & tx_word.send_check;
  wire tx_finish   = tx_cts_lost | (tx_char_end & ~tx_to_check);
  wire [7:0] tx_src = tx_load ? tx_char : tx_shift;
  wire tx_bit      = tx_rev ? tx_src[7] : tx_src[0];
  wire [7:0] tx_rest = tx_rev ? {tx_src[6:0], 1'b0} : {1'b0, tx_src[7:1]};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_cnt   <= 3'h0;
      tx_acc   <= 16'h0000;
      txd_out  <= 1'b1;
      rts_out  <= 1'b0;
    end else if (tx_load) begin
      tx_state <= TX_CHAR;
      txd_out  <= tx_bit;
      tx_shift <= tx_rest;
      tx_cnt   <= 3'h1;
      rts_out  <= 1'b1;
      tx_acc   <= check_step(~tx_par_on, tx_acc, tx_char);
    end else if (tx_cts_lost) begin
      tx_state <= TX_IDLE;
      txd_out  <= 1'b1;
      rts_out  <= 1'b0;
    end else if (line_fall && tx_state != TX_IDLE) begin
      txd_out  <= tx_bit;
      tx_shift <= tx_rest;
      tx_cnt   <= tx_cnt + 3'h1;
      if (tx_to_check) begin
        tx_state <= TX_CHECK;
        tx_shift <= tx_acc[7:0];
        tx_cnt   <= 3'h0;
      end else if (tx_char_end) begin
        // rts drops as the final bit starts; next ready buffer may follow
        tx_state <= TX_IDLE;
        rts_out  <= 1'b0;
        if (tx_state == TX_CHECK) tx_acc <= 16'h0000;
      end
    end else if (line_fall) begin
      txd_out <= 1'b1;
    end
  end

  // descriptor tables, controller updates beat software writes
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < DESC_N; i++) begin
      if (sys_rst_in) begin
        rx_desc[i] <= '0;
        tx_desc[i] <= '0;
      end else begin
        if ((store_en || rx_close) && rx_cur == i[IDX_W-1:0]) rx_desc[i] <= next_rx_word;
        else if (sw_rx_desc && wr_idx == i[IDX_W-1:0]) rx_desc[i] <= rx_desc_t'(hwdata_in);
        if (tx_finish && tx_cur == i[IDX_W-1:0]) begin
          tx_desc[i].ready    <= 1'b0;
          tx_desc[i].cts_lost <= tx_cts_lost;
        end else if (sw_tx_desc && wr_idx == i[IDX_W-1:0]) begin
          tx_desc[i] <= tx_desc_t'(hwdata_in);
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode    <= mode_t'(MODE_RESET);
      rx_base <= '0;
      tx_base <= '0;
      rx_cur  <= '0;
      tx_cur  <= '0;
    end else begin
      if (sw_mode) mode <= mode_t'(hwdata_in[15:0] & MODE_WMASK);
      if (sw_rx_base) rx_base <= hwdata_in[IDX_W-1:0];
      if (sw_tx_base) tx_base <= hwdata_in[IDX_W-1:0];
      if (rx_close) rx_cur <= rx_desc[rx_cur].wrap ? rx_base : rx_cur + 1'b1;
      else if (sw_rx_base) rx_cur <= hwdata_in[IDX_W-1:0];
      if (tx_finish) tx_cur <= tx_word.wrap ? tx_base : tx_cur + 1'b1;
      else if (sw_tx_base) tx_cur <= hwdata_in[IDX_W-1:0];
    end
  end

  // sticky events: a set in the clearing cycle survives
  logic [15:0] ev_set;
  always_comb begin
    ev_set          = 16'h0000;
    ev_set[EV_RX]   = rx_close & rx_desc[rx_cur].notify;
    ev_set[EV_TX]   = tx_finish & ~tx_cts_lost & tx_word.notify;
    ev_set[EV_TXE]  = tx_cts_lost & tx_word.notify;
    ev_set[EV_BUSY] = busy_ev;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) events <= 16'h0000;
    else events <= (events & ~(sw_event ? hwdata_in[15:0] : 16'h0000)) | ev_set;
  end

endmodule

/* inc/bisync_pkg.sv */
package bisync_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS    = 8'h00;
  localparam logic [7:0] RX_BASE_OFS = 8'h04;
  localparam logic [7:0] TX_BASE_OFS = 8'h08;
  localparam logic [7:0] RX_ACC_OFS  = 8'h0C;
  localparam logic [7:0] CMD_OFS     = 8'h10;
  localparam logic [7:0] EVENT_OFS   = 8'h14;
  localparam logic [7:0] STATE_OFS   = 8'h18;
  localparam logic [7:0] RX_DESC_OFS = 8'h40;
  localparam logic [7:0] TX_DESC_OFS = 8'h60;

  localparam int unsigned DESC_N = 4;
  localparam int unsigned IDX_W  = 2;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hFFCF;

  localparam logic [1:0] CHECK_CRC16 = 2'h1;
  localparam logic [1:0] CHECK_LRC   = 2'h3;

  localparam logic [1:0] PAR_ODD  = 2'h0;
  localparam logic [1:0] PAR_LOW  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_HIGH = 2'h3;

  localparam logic [7:0]  SYNC_CHAR  = 8'h32;
  localparam logic [7:0]  DLE_CHAR   = 8'h10;
  localparam logic [7:0]  CTRL_CHAR  = 8'h03;
  localparam logic [15:0] CRC16_POLY = 16'hA001;
  localparam logic [15:0] RX_BUF_LEN = 16'h0010;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  localparam int unsigned CMD_HUNT_BIT  = 0;
  localparam int unsigned CMD_CLOSE_BIT = 1;
  localparam int unsigned EV_RX   = 0;
  localparam int unsigned EV_TX   = 1;
  localparam int unsigned EV_BUSY = 2;
  localparam int unsigned EV_TXE  = 4;

  typedef struct packed {
    logic [3:0] sync_count;
    logic [1:0] check_sel;
    logic       receive_check_include;
    logic       receive_transparent;
    logic       bit_order_reverse;
    logic       receive_gate_during_transmit;
    logic [1:0] spare;
    logic [1:0] receive_parity_select;
    logic [1:0] transmit_parity_select;
  } mode_t;

  typedef struct packed {
    logic        owned;
    logic        wrap;
    logic        notify;
    logic        descriptor_continuous;
    logic        dpll_fault_flag;
    logic        rx_overrun_flag;
    logic        carrier_lost_flag;
    logic        parity_error;
    logic [7:0]  last_char;
    logic [15:0] length;
  } rx_desc_t;

  typedef struct packed {
    logic        ready;
    logic        wrap;
    logic        notify;
    logic        last;
    logic        send_check;
    logic        cts_lost;
    logic [17:0] spare;
    logic [7:0]  data;
  } tx_desc_t;

  typedef enum logic [1:0] {RX_HUNT = 2'h0, RX_DATA = 2'h1, RX_ESC = 2'h3} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_CHAR = 2'h1, TX_CHECK = 2'h3} tx_state_t;

endpackage

/* dv/bisync_core_monitor.sv */
`timescale 1ns/10ps
module bisync_core_monitor (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        line_clk_in,
  input wire logic        clear_to_send_n_in,
  input wire logic        txd_out,
  input wire logic        rts_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // cycles since rts dropped; last bit plus sync delay stays well under 40
  logic [5:0] low_cnt;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || rts_out) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3F) low_cnt <= low_cnt + 6'h01;
  end

  property p_resp_okay;
    hresp_out == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("hresp not OKAY");
  property p_ready_up;
    !$past(sys_rst_in) |-> hreadyout_out;
  endproperty
  a_ready_up: assert property (p_ready_up) else $error("hreadyout low after reset");
  property p_rdata_stands;
    !(hsel_in && htrans_in[1] && !hwrite_in && hready_in) |=> $stable(hrdata_out);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("hrdata moved without a read");
  property p_txd_on_fall;
    $changed(txd_out) && !clear_to_send_n_in && !$past(clear_to_send_n_in, 4) |-> !line_clk_in;
  endproperty
  a_txd_on_fall: assert property (p_txd_on_fall) else $error("txd moved off a line fall");
  property p_rts_rise;
    $rose(rts_out) |-> !line_clk_in;
  endproperty
  a_rts_rise: assert property (p_rts_rise) else $error("rts rose off a line fall");
  property p_rts_holds;
    $rose(rts_out) && !clear_to_send_n_in |=> rts_out [*8];
  endproperty
  a_rts_holds: assert property (p_rts_holds) else $error("rts dropped early");
  property p_rts_fall;
    $fell(rts_out) && !clear_to_send_n_in |-> !line_clk_in;
  endproperty
  a_rts_fall: assert property (p_rts_fall) else $error("rts fell off a line fall");
  property p_cts_abort;
    rts_out && clear_to_send_n_in |-> ##[0:8] (!rts_out && txd_out);
  endproperty
  a_cts_abort: assert property (p_cts_abort) else $error("no abort on lost cts");
  property p_idle_high;
    low_cnt >= 6'h28 |-> txd_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("txd not idle high");
endmodule

bind bisync_core bisync_core_monitor mon_u (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .line_clk_in(line_clk_in),
  .clear_to_send_n_in(clear_to_send_n_in), .txd_out(txd_out), .rts_out(rts_out)
);

/* dv/serial_line_model.sv */
`timescale 1ns/10ps
module serial_line_model (
  output logic      line_clk_out,
  output logic      rxd_out,
  input  wire logic txd_in
);
  logic [15:0] cap;
  initial begin
    line_clk_out = 1'b0;
    rxd_out = 1'b1;
    cap = 16'h0000;
  end
  // clock runs only inside a burst; bits[0] goes first, txd taken on each rise
  task automatic shift(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_out <= bits[i];
      #62.5 line_clk_out <= 1'b1;
      cap <= {txd_in, cap[15:1]};
      // released line shows the inverse so a stale level never reads as data
      #31.25 if (i == n - 1) rxd_out <= ~rxd_out;
      #31.25 line_clk_out <= 1'b0;
    end
  endtask
endmodule

/* dv/bisync_protocol_buffering_tb.sv */
`timescale 1ns/10ps
module bisync_protocol_buffering_tb
  import bisync_pkg::*;
;
  logic        clk_in;
  logic        sys_rst_in;
  logic        hsel;
  logic        hwrite;
  logic        cd_n;
  logic        cts_n;
  logic        dpll;
  logic        rev;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        txd;
  logic        rts;
  logic        lclk;
  logic        rxd;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  bisync_core dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .line_clk_in(lclk), .rxd_in(rxd), .carrier_detect_n_in(cd_n),
    .clear_to_send_n_in(cts_n), .dpll_fault_in(dpll), .txd_out(txd), .rts_out(rts)
  );
  serial_line_model line_u (.line_clk_out(lclk), .rxd_out(rxd), .txd_in(txd));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hang anywhere ends here; the whole run needs about 11500 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    n_tests++;
    if ((q & m) !== (e & m)) begin
      n_errors++;
      $display("ERROR reg %h expected %h seen %h", a, e & m, q & m);
    end
  endtask
  // serial crc16 reference, lsb first
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c = (c >> 1) ^ (fb ? CRC16_POLY : 16'h0000);
    end
    return c;
  endfunction
  function automatic logic [7:0] bo(input logic [7:0] b);
    logic [7:0] r;
    r = {<<{b}};
    return rev ? r : b;
  endfunction
  // leading ones keep the hunt window from matching early
  task automatic frame(input logic [7:0] q[$]);
    line_u.shift(16'h00FF, 8);
    line_u.shift({8'h00, bo(SYNC_CHAR)}, 8);
    foreach (q[i]) line_u.shift({8'h00, bo(q[i])}, 8);
    repeat (10) @(posedge clk_in);
  endtask

  initial begin
    {sys_rst_in, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    {cd_n, cts_n, dpll, rev} = 4'h0;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(MODE_OFS, {16'h0000, MODE_RESET}, 32'hFFFFFFFF);
    wr(8'h20, 32'hFFFFFFFF);
    chk(8'h20, 32'h00000000, 32'hFFFFFFFF);
    wr(MODE_OFS, 32'h0000FFFF);
    chk(MODE_OFS, {16'h0000, MODE_WMASK}, 32'hFFFFFFFF);
    wr(MODE_OFS, 32'h00000400);
    wr(RX_DESC_OFS, 32'hA0000000);
    wr(RX_DESC_OFS + 8'h04, 32'hE0000000);
    frame('{8'h41, SYNC_CHAR, CTRL_CHAR});
    chk(RX_DESC_OFS, 32'h00030002, 32'h8FFFFFFF);
    chk(EVENT_OFS, 32'h00000001, 32'h00000017);
    wr(EVENT_OFS, 32'h00000017);
    chk(STATE_OFS, 32'h00000004, 32'h0000000C);
    rev = 1'b1;
    wr(MODE_OFS, 32'h00000480);
    frame('{8'h41, CTRL_CHAR});
    chk(RX_DESC_OFS + 8'h04, 32'h00030002, 32'h8FFFFFFF);
    chk(STATE_OFS, 32'h00000000, 32'h0000000C);
    rev = 1'b0;
    wr(MODE_OFS, 32'h00000400);
    wr(RX_DESC_OFS, 32'hC0000000);
    frame('{8'h41});
    wr(CMD_OFS, 32'h00000002);
    wr(CMD_OFS, 32'h00000001);
    chk(RX_DESC_OFS, 32'h00410001, 32'h8FFFFFFF);
    for (int p = 0; p < 4; p++) begin
      wr(MODE_OFS, 32'h00000C00 | (32'(p) << 2));
      wr(RX_DESC_OFS, 32'hC0000000);
      frame('{(p == 0 || p == 3) ? 8'hC1 : 8'h41, (p == 0 || p == 3) ? 8'h41 : 8'hC1});
      chk(RX_DESC_OFS, 32'h01000002, 32'h8100FFFF);
    end
    wr(MODE_OFS, 32'h00000400);
    for (int k = 0; k < 2; k++) begin
      wr(RX_DESC_OFS, 32'hC0000000);
      frame('{8'h41});
      @(posedge clk_in);
      if (k == 0) cd_n <= 1'b1;
      else dpll <= 1'b1;
      line_u.shift(16'h0041, 8);
      @(posedge clk_in);
      {cd_n, dpll} <= 2'h0;
      repeat (10) @(posedge clk_in);
      chk(RX_DESC_OFS, (k == 0) ? 32'h02000000 : 32'h08000000, 32'h8E000000);
    end
    for (int p = 0; p < 4; p++) begin
      wr(MODE_OFS, 32'h00000C00 | 32'(p));
      wr(TX_DESC_OFS, 32'hF0000041);
      line_u.shift(16'hFFFF, 9);
      repeat (10) @(posedge clk_in);
      n_tests++;
      if (line_u.cap[15:8] !== {(p == 0 || p == 3) ? 1'b1 : 1'b0, 7'h41}) begin
        n_errors++;
        $display("ERROR tx char expected %h seen %h", {p == 0 || p == 3, 7'h41}, line_u.cap[15:8]);
      end
      chk(TX_DESC_OFS, 32'h00000000, 32'h84000000);
      chk(EVENT_OFS, 32'h00000002, 32'h00000012);
      wr(EVENT_OFS, 32'h00000017);
    end
    wr(TX_DESC_OFS, 32'hE0000041);
    fork
      line_u.shift(16'hFFFF, 9);
      begin
        repeat (100) @(posedge clk_in);
        cts_n <= 1'b1;
      end
    join
    @(posedge clk_in);
    cts_n <= 1'b0;
    chk(TX_DESC_OFS, 32'h04000000, 32'h84000000);
    chk(EVENT_OFS, 32'h00000010, 32'h00000012);
    // transmit with check byte spans the sync, so a gated receiver never locks
    wr(MODE_OFS, 32'h00000440);
    wr(RX_DESC_OFS, 32'hC0000000);
    wr(TX_DESC_OFS, 32'hD8000041);
    frame('{8'hFF});
    chk(RX_DESC_OFS, 32'h80000000, 32'h8000FFFF);
    chk(TX_DESC_OFS, 32'h00000000, 32'h80000000);
    wr(CMD_OFS, 32'h00000002);
    wr(RX_ACC_OFS, 32'h00000000);
    wr(MODE_OFS, 32'h00000600);
    wr(RX_DESC_OFS, 32'hC0000000);
    frame('{8'h41});
    wr(MODE_OFS, 32'h00000400);
    line_u.shift(16'h0042, 8);
    repeat (10) @(posedge clk_in);
    wr(MODE_OFS, 32'h00000600);
    chk(RX_ACC_OFS, {16'h0000, crc_ref(16'h0000, 8'h42)}, 32'h0000FFFF);
    wr(CMD_OFS, 32'h00000001);
    wr(RX_ACC_OFS, 32'h00000000);
    wr(MODE_OFS, 32'h00000F00);
    wr(RX_DESC_OFS, 32'hC0000000);
    frame('{DLE_CHAR, SYNC_CHAR, CTRL_CHAR, DLE_CHAR, CTRL_CHAR});
    chk(RX_DESC_OFS, 32'h00030002, 32'h8FFFFFFF);
    chk(RX_ACC_OFS, {16'h0000, crc_ref(crc_ref(16'h0000, CTRL_CHAR), CTRL_CHAR)},
        32'h0000FFFF);
    give_verdict();
  end
endmodule
